// file: rtl/charge_time_unit.v
// charge time unit control: registers, edge flags, current gate, irq flag
`timescale 1ns/1ps
`include "charge_time_unit_defs.vh"
// Function
// - two-bit current range, zero lowest
// - six-bit signed trim in bits 7:2
// - per-channel two-bit source select fields
// - channels respond to level, not transition
// - polarity bits, reset to negative
// - sequencing: channel two only with or after one
// - hardware sets channel flags on response
// - config matching level sets flag immediately
// - current on when exactly one flag
// - software may write flags directly
// - irq flag set on current off
// - irq request needs flag and enable
// - mode bit, measurement mode by default
// - discharge bit drains the circuit
// - unit enable and edge inputs enable
// - timer and compare triggers as sources
module charge_time_unit (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // edge sources
  input wire edge_pin_one,
  input wire edge_pin_two,
  input wire timer_trigger,
  input wire compare_trigger,
  // analog controls
  output reg current_on,
  output reg discharge,
  output reg [1:0] current_range_sel,
  output reg [5:0] current_trim,
  output reg delay_mode_sel,
  output reg unit_enable,
  // interrupt request
  output reg irq
);
  // stored registers
  reg [7:0] icon_q;
  reg [7:0] conl_q;
  reg [7:0] conh_q;
  reg irq_flag_q;
  reg irq_en_q;
  reg cur_prev_q;
  reg chan1_seen_q;

  // bus decode
  wire wr_en;
  wire rd_en;
  wire hit;
  wire wr_icon;
  wire wr_conl;
  wire wr_conh;
  wire wr_irqf;
  wire wr_irqe;

  // edge detection and current gate
  wire act1;
  wire act2;
  wire edges_live;
  wire set1;
  wire set2;
  wire cur_now;
  wire cur_fall;
  wire [7:0] conl_wr;
  wire [7:0] conh_wr;
  reg [7:0] conl_d;
  reg [31:0] prdata_d;

  // true when the bus address names the given register
  function addr_is;
    input [11:0] a;
    input [11:0] off;
    begin
      addr_is = (a == off);
    end
  endfunction

  // an 8-bit register sits in the low byte of its bus word
  function [31:0] byte_word;
    input [7:0] b;
    begin
      byte_word = {24'h000000, b};
    end
  endfunction

  // irq flag and enable share one bit position
  function [31:0] irq_word;
    input f;
    begin
      irq_word = {29'h0000000, f, 2'h0};
    end
  endfunction

  // hardware set wins over a software clear in the same cycle
  function flag_next;
    input sw_val;
    input hw_set;
    begin
      flag_next = sw_val | hw_set;
    end
  endfunction

  // single-cycle access phase, never waits
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  // read data is captured at the setup edge, so the access phase never waits
  assign rd_en = psel & ~penable & ~pwrite;
  assign hit = addr_is(paddr, `OFF_CURRENT_SOURCE_CONTROL) |
               addr_is(paddr, `OFF_EDGE_CONFIG_AND_FLAGS) |
               addr_is(paddr, `OFF_UNIT_MAIN_CONTROL) |
               addr_is(paddr, `OFF_PERIPH_IRQ_FLAGS) |
               addr_is(paddr, `OFF_PERIPH_IRQ_ENABLES);
  assign pslverr = psel & penable & ~hit;

  // one write strobe per register, taken in the access phase
  assign wr_icon = wr_en & addr_is(paddr, `OFF_CURRENT_SOURCE_CONTROL);
  assign wr_conl = wr_en & addr_is(paddr, `OFF_EDGE_CONFIG_AND_FLAGS);
  assign wr_conh = wr_en & addr_is(paddr, `OFF_UNIT_MAIN_CONTROL);
  assign wr_irqf = wr_en & addr_is(paddr, `OFF_PERIPH_IRQ_FLAGS);
  assign wr_irqe = wr_en & addr_is(paddr, `OFF_PERIPH_IRQ_ENABLES);

  // channel detectors see the config about to be stored, so a config write
  // that matches the present level sets the flag at once
  assign conl_wr = wr_conl ? pwdata[7:0] : conl_q;
  // bits 6:4 of the main control are not implemented and read zero
  assign conh_wr = {pwdata[7], 3'h0, pwdata[3:0]};

  // channel one
  edge_channel u_chan1 (
    .edge_pin_one(edge_pin_one),
    .edge_pin_two(edge_pin_two),
    .timer_trigger(timer_trigger),
    .compare_trigger(compare_trigger),
    .source_sel(conl_wr[`CHAN1_SEL_MSB:`CHAN1_SEL_LSB]),
    .polarity(conl_wr[`CHAN1_POL_BIT]),
    .active(act1)
  );

  // channel two
  edge_channel u_chan2 (
    .edge_pin_one(edge_pin_one),
    .edge_pin_two(edge_pin_two),
    .timer_trigger(timer_trigger),
    .compare_trigger(compare_trigger),
    .source_sel(conl_wr[`CHAN2_SEL_MSB:`CHAN2_SEL_LSB]),
    .polarity(conl_wr[`CHAN2_POL_BIT]),
    .active(act2)
  );

  // edges blocked unless unit and edge inputs are both enabled
  assign edges_live = conh_q[`UNIT_EN_BIT] & conh_q[`EDGE_EN_BIT];
  assign set1 = edges_live & act1;
  // with sequencing, channel two waits for a channel one event
  assign set2 = edges_live & act2 &
                (~conh_q[`SEQ_EN_BIT] | chan1_seen_q | set1);

  // flag update: software write first, then hardware sets on top
  always @* begin
    conl_d = conl_wr;
    conl_d[`CHAN1_FLAG_BIT] = flag_next(conl_wr[`CHAN1_FLAG_BIT], set1);
    conl_d[`CHAN2_FLAG_BIT] = flag_next(conl_wr[`CHAN2_FLAG_BIT], set2);
  end

  // current gate uses the stored flags; exactly one set
  assign cur_now = conl_q[`CHAN1_FLAG_BIT] ^ conl_q[`CHAN2_FLAG_BIT];
  assign cur_fall = cur_prev_q & ~cur_now;

  // current range and trim, plain read-write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icon_q <= `RST_CURRENT_SOURCE_CONTROL;
    end else if (wr_icon) begin
      icon_q <= pwdata[7:0];
    end
  end

  // main control, unused bits kept at zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conh_q <= `RST_UNIT_MAIN_CONTROL;
    end else if (wr_conh) begin
      conh_q <= conh_wr;
    end
  end

  // interrupt enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= `RST_IRQ;
    end else if (wr_irqe) begin
      irq_en_q <= pwdata[`IRQ_BIT];
    end
  end

  // flags only fall by a write, never by input level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conl_q <= `RST_EDGE_CONFIG_AND_FLAGS;
    end else begin
      conl_q <= conl_d;
    end
  end

  // sequencing memory: channel one seen since flag cleared
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_seen_q <= 1'b0;
    end else begin
      chan1_seen_q <= conl_d[`CHAN1_FLAG_BIT];
    end
  end

  // previous gate state for the turn-off detector
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_prev_q <= 1'b0;
    end else begin
      cur_prev_q <= cur_now;
    end
  end

  // interrupt flag: fall of current sets it, set wins over a write of zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_q <= `RST_IRQ;
    end else if (cur_fall) begin
      irq_flag_q <= 1'b1;
    end else if (wr_irqf) begin
      irq_flag_q <= pwdata[`IRQ_BIT];
    end
  end

  // request registered so it never glitches on bus decode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_flag_q & irq_en_q;
    end
  end

  // current source drive; a disabled unit never charges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_on <= 1'b0;
    end else begin
      current_on <= cur_now & conh_q[`UNIT_EN_BIT];
    end
  end

  // range and trim copies for the analog source
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_range_sel <= 2'h0;
      current_trim <= 6'h00;
    end else begin
      current_range_sel <= icon_q[`RANGE_MSB:`RANGE_LSB];
      current_trim <= icon_q[`TRIM_MSB:`TRIM_LSB];
    end
  end

  // mode, discharge and enable copies, one cycle behind the register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discharge <= 1'b0;
      delay_mode_sel <= 1'b0;
      unit_enable <= 1'b0;
    end else begin
      discharge <= conh_q[`DISCHARGE_BIT];
      delay_mode_sel <= conh_q[`DELAY_MODE_BIT];
      unit_enable <= conh_q[`UNIT_EN_BIT];
    end
  end

  // read select, unmapped addresses read zero
  always @* begin
    prdata_d = 32'h00000000;
    case (paddr)
      `OFF_CURRENT_SOURCE_CONTROL: prdata_d = byte_word(icon_q);
      `OFF_EDGE_CONFIG_AND_FLAGS: prdata_d = byte_word(conl_q);
      `OFF_UNIT_MAIN_CONTROL: prdata_d = byte_word(conh_q);
      `OFF_PERIPH_IRQ_FLAGS: prdata_d = irq_word(irq_flag_q);
      `OFF_PERIPH_IRQ_ENABLES: prdata_d = irq_word(irq_en_q);
      default: prdata_d = 32'h00000000;
    endcase
  end

  // read data stands from the setup edge until the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= prdata_d;
    end
  end
endmodule // charge_time_unit

// file: rtl/charge_time_unit_defs.vh
// register offsets, field positions and reset values for the charge time unit
`ifndef CHARGE_TIME_UNIT_DEFS_VH
`define CHARGE_TIME_UNIT_DEFS_VH
// byte addresses on the apb bus
`define OFF_CURRENT_SOURCE_CONTROL 12'h000
`define OFF_EDGE_CONFIG_AND_FLAGS 12'h004
`define OFF_UNIT_MAIN_CONTROL 12'h008
`define OFF_PERIPH_IRQ_FLAGS 12'h00C
`define OFF_PERIPH_IRQ_ENABLES 12'h010
// current_source_control fields
`define RANGE_LSB 0
`define RANGE_MSB 1
`define TRIM_LSB 2
`define TRIM_MSB 7
// edge_config_and_flags fields
`define CHAN1_FLAG_BIT 0
`define CHAN2_FLAG_BIT 1
`define CHAN1_SEL_LSB 2
`define CHAN1_SEL_MSB 3
`define CHAN1_POL_BIT 4
`define CHAN2_SEL_LSB 5
`define CHAN2_SEL_MSB 6
`define CHAN2_POL_BIT 7
// unit_main_control fields
`define DELAY_MODE_BIT 0
`define DISCHARGE_BIT 1
`define SEQ_EN_BIT 2
`define EDGE_EN_BIT 3
`define UNIT_EN_BIT 7
// interrupt flag and enable position
`define IRQ_BIT 2
// reset values
`define RST_CURRENT_SOURCE_CONTROL 8'h00
`define RST_EDGE_CONFIG_AND_FLAGS 8'h00
`define RST_UNIT_MAIN_CONTROL 8'h00
`define RST_IRQ 1'b0
// edge source codes
`define SRC_PIN_ONE 2'h0
`define SRC_PIN_TWO 2'h1
`define SRC_TIMER 2'h2
`define SRC_COMPARE 2'h3
`endif

// file: rtl/edge_channel.v
// one level-sensitive edge channel: source select and polarity
`timescale 1ns/1ps
`include "charge_time_unit_defs.vh"
module edge_channel (
  // selected sources
  input wire edge_pin_one,
  input wire edge_pin_two,
  input wire timer_trigger,
  input wire compare_trigger,
  // configuration
  input wire [1:0] source_sel,
  input wire polarity,
  // qualifying level
  output reg active
);
  reg lvl;
  // pick source, then polarity 0 means low level qualifies
  always @* begin
    case (source_sel)
      `SRC_PIN_ONE: lvl = edge_pin_one;
      `SRC_PIN_TWO: lvl = edge_pin_two;
      `SRC_TIMER: lvl = timer_trigger;
      `SRC_COMPARE: lvl = compare_trigger;
      default: lvl = 1'b0;
    endcase
    active = polarity ? lvl : ~lvl;
  end
endmodule // edge_channel

// file: verification/charge_time_unit_asserts.sv
// port checker for the charge time unit
`timescale 1ns/1ps
module ctu_chk (
  // apb side, ports grouped to save room
  input wire pclk, input wire presetn, input wire psel, input wire penable,
  input wire pwrite, input wire [11:0] paddr, input wire [31:0] pwdata,
  input wire pready, input wire pslverr,
  // analog controls
  input wire current_on, input wire discharge, input wire [1:0] current_range_sel,
  input wire [5:0] current_trim, input wire delay_mode_sel, input wire unit_enable,
  // interrupt request
  input wire irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access decode; outputs follow a write two edges later
  wire acc = psel & penable;
  wire hit = (paddr <= 12'h010) && (paddr[1:0] == 2'h0);
  wire wr0 = acc & pwrite & (paddr == 12'h000);
  wire wr8 = acc & pwrite & (paddr == 12'h008);
  // enable as software last wrote it, for the request check
  reg ien_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= 1'b0;
    end else if (acc & pwrite & (paddr == 12'h010)) begin
      ien_q <= pwdata[2];
    end
  end
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_slverr; acc |-> (pslverr == !hit); endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
  property p_range; wr0 |-> ##2 current_range_sel == $past(pwdata[1:0], 2); endproperty
  a_range: assert property (p_range) else $error("range wrong");
  property p_trim; wr0 |-> ##2 current_trim == $past(pwdata[7:2], 2); endproperty
  a_trim: assert property (p_trim) else $error("trim wrong");
  property p_uen; wr8 |-> ##2 unit_enable == $past(pwdata[7], 2); endproperty
  a_uen: assert property (p_uen) else $error("enable wrong");
  property p_dis; wr8 |-> ##2 discharge == $past(pwdata[1], 2); endproperty
  a_dis: assert property (p_dis) else $error("discharge wrong");
  property p_mode; wr8 |-> ##2 delay_mode_sel == $past(pwdata[0], 2); endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_on; current_on |-> unit_enable; endproperty
  a_on: assert property (p_on) else $error("current without enable");
  property p_irq; irq |-> $past(ien_q); endproperty
  a_irq: assert property (p_irq) else $error("irq while disabled");
endmodule // ctu_chk
bind charge_time_unit ctu_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .current_on, .discharge, .current_range_sel, .current_trim,
  .delay_mode_sel, .unit_enable, .irq);

// file: verification/charge_time_unit_tb_top.sv
// self-checking bench for the charge time unit
`timescale 1ns/1ps
module charge_time_unit_tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [3:0] cmd = 4'hF;
  reg [7:0] c;
  wire [3:0] src;
  wire [31:0] prdata;
  wire [1:0] rng;
  wire [5:0] trim;
  wire pready, pslverr, con, dis, mode, uen, irq;
  integer n_errors = 0, tests_run = 0, i;
  always #2.5 pclk = ~pclk;
  edge_src_model m_u (.pclk(pclk), .lvl_cmd(cmd), .src_q(src));
  charge_time_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .edge_pin_one(src[0]), .edge_pin_two(src[1]), .timer_trigger(src[2]),
    .compare_trigger(src[3]), .current_on(con), .discharge(dis), .current_range_sel(rng),
    .current_trim(trim), .delay_mode_sel(mode), .unit_enable(uen), .irq(irq));
  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // one apb transfer; read data taken at the pready edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // margin covers source, flag, gate and irq flops
  task st;
    begin
      repeat (6) @(posedge pclk);
      #1;
    end
  endtask
  task cw(input [7:0] d);
    begin
      apb(1'b1, 12'h000, d);
      st;
      chk({trim, rng}, d);
      apb(1'b0, 12'h000, 0);
      chk(rd, d);
    end
  endtask
  task t_reset;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        apb(1'b0, {i[9:0], 2'b00}, 0);
        chk(rd, 0);
      end
      chk({con, dis, rng, trim, mode, uen, irq}, 0);
      $display("t_reset done");
    end
  endtask
  task t_ctrl;
    begin
      cw(8'h80);
      cw(8'h7D);
      cw(8'h02);
      apb(1'b1, 12'h008, 8'hFF);
      st;
      chk({uen, dis, mode}, 3'h7);
      apb(1'b0, 12'h008, 0);
      chk(rd, 8'h8F);
      $display("t_ctrl done");
    end
  endtask
  task t_edge;
    begin
      apb(1'b1, 12'h010, 4);
      apb(1'b1, 12'h008, 8'h88);
      for (i = 0; i < 4; i = i + 1) begin
        c = {1'b0, i[1:0] + 2'h1, 1'b0, i[1:0], 2'h0};
        apb(1'b1, 12'h004, c);
        cmd <= ~(4'h1 << i);
        st;
        apb(1'b0, 12'h004, 0);
        chk(rd, c | 8'h01);
        chk(con, 1);
        c = {1'b0, i[1:0], 1'b0, i[1:0], 2'h1};
        apb(1'b1, 12'h004, c);
        st;
        chk({con, irq}, 2'h1);
        cmd <= 4'hF;
        st;
        apb(1'b0, 12'h004, 0);
        chk(rd, c | 8'h02);
        apb(1'b1, 12'h004, 0);
        apb(1'b1, 12'h00C, 0);
        st;
        chk({con, irq}, 2'h0);
      end
      $display("t_edge done");
    end
  endtask
  task t_seq;
    begin
      apb(1'b1, 12'h008, 8'h8C);
      apb(1'b1, 12'h004, 8'h20);
      cmd <= 4'hD;
      st;
      apb(1'b0, 12'h004, 0);
      chk(rd, 8'h20);
      cmd <= 4'hC;
      st;
      apb(1'b0, 12'h004, 0);
      chk(rd, 8'h23);
      cmd <= 4'hF;
      apb(1'b1, 12'h004, 0);
      $display("t_seq done");
    end
  endtask
  // edge inputs off, then software-driven flags with irq masked
  task t_sw;
    begin
      apb(1'b1, 12'h008, 8'h80);
      apb(1'b1, 12'h010, 0);
      apb(1'b1, 12'h00C, 0);
      cmd <= 4'hE;
      st;
      apb(1'b0, 12'h004, 0);
      chk(rd, 0);
      apb(1'b1, 12'h004, 1);
      st;
      chk(con, 1);
      apb(1'b1, 12'h004, 3);
      st;
      chk({con, irq}, 2'h0);
      apb(1'b0, 12'h00C, 0);
      chk(rd, 4);
      $display("t_sw done");
    end
  endtask
  // channel one positive polarity, brought up in the recommended order
  task t_pol;
    begin
      apb(1'b1, 12'h008, 8'h80);
      apb(1'b1, 12'h004, 8'h30);
      st;
      chk(con, 0);
      apb(1'b1, 12'h008, 8'h88);
      st;
      apb(1'b0, 12'h004, 0);
      chk(rd, 8'h31);
      chk(con, 1);
      cmd <= 4'hD;
      st;
      apb(1'b0, 12'h004, 0);
      chk(rd, 8'h33);
      chk({con, irq}, 2'h1);
      apb(1'b1, 12'h004, 0);
      apb(1'b1, 12'h00C, 0);
      cmd <= 4'hF;
      $display("t_pol done");
    end
  endtask
  // reset in mid-run clears outputs and registers
  task t_mid;
    begin
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({con, dis, rng, trim, mode, uen, irq}, 0);
      presetn <= 1'b1;
      apb(1'b0, 12'h004, 0);
      chk(rd, 0);
      apb(1'b0, 12'h00C, 0);
      chk(rd, 0);
      $display("t_mid done");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_ctrl;
    t_edge;
    t_seq;
    t_pol;
    t_sw;
    t_mid;
    report_and_stop;
  end
  // watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors = n_errors + 1;
    report_and_stop;
  end
endmodule // charge_time_unit_tb_top

// file: verification/edge_src_model.sv
// edge trigger sources seen by the charge time unit
`timescale 1ns/1ps
module edge_src_model (
  // bench control
  input wire pclk,
  input wire [3:0] lvl_cmd,
  // pin one, pin two, timer, compare
  output reg [3:0] src_q
);
  // sources idle high so that the default low polarity sees no event
  initial src_q = 4'hF;
  // levels follow the command one cycle late, like a synchronous source
  always @(posedge pclk) begin
    src_q <= lvl_cmd;
  end
endmodule // edge_src_model
